// [logic/dmscp_device.sv]
`timescale 1ns/1ps
`include "dmscp_cfg.svh"

module dmscp_device #(
    parameter int ADDR_W     = `DMSCP_ADDR_W,
    parameter int MSB_RW_POS = `DMSCP_MSB_RW_POS,
    parameter int MSB_ALSB   = `DMSCP_MSB_ADDR_LSB,
    parameter int LSB_RW_POS = `DMSCP_LSB_RW_POS,
    parameter int LSB_ALSB   = `DMSCP_LSB_ADDR_LSB
) (
    dmscp_if.device          link,
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        stream_bus_mode,
    input  wire logic        contention,
    output logic             mic_gain_boost,
    output logic [1:0]       speaker_gain_step,
    output logic [7:0]       gain_control_one,
    output logic             irq_n_o,
    output logic             irq_n_oe
);

    // Built one bit wider so a seven-bit field cannot overflow
    localparam logic [7:0] AMASK = 8'((9'h001 << ADDR_W) - 9'h001);

    if (ADDR_W < 1 || ADDR_W > 7) begin : g_chk_aw
        $error("dmscp_device: address width out of range");
    end
    if (MSB_ALSB + ADDR_W > 8 || LSB_ALSB + ADDR_W > 8) begin : g_chk_fit
        $error("dmscp_device: address field exceeds command byte");
    end
    if ((MSB_RW_POS >= MSB_ALSB && MSB_RW_POS < MSB_ALSB + ADDR_W) ||
        (LSB_RW_POS >= LSB_ALSB && LSB_RW_POS < LSB_ALSB + ADDR_W)) begin : g_chk_rw
        $error("dmscp_device: direction flag overlaps address field");
    end
    if (MSB_RW_POS < 0 || MSB_RW_POS > 7 || LSB_RW_POS < 0 || LSB_RW_POS > 7) begin : g_chk_rwpos
        $error("dmscp_device: direction flag outside command byte");
    end
    if (MSB_ALSB < 0 || LSB_ALSB < 0) begin : g_chk_alsb
        $error("dmscp_device: negative address field position");
    end
    // Register address must be reachable through the address field
    if ((`DMSCP_GAIN1_ADDR & ~AMASK) != 8'h00) begin : g_chk_reg
        $error("dmscp_device: register address wider than address field");
    end
    // Counter end points are used as a set and must agree
    if (`DMSCP_DATA_FIRST != `DMSCP_BYTE_LAST + 5'h01 ||
        `DMSCP_FRAME_BITS != `DMSCP_FRAME_LAST + 5'h01) begin : g_chk_cnt
        $error("dmscp_device: bit count constants disagree");
    end
    if (`DMSCP_MIC_BIT > 7 || `DMSCP_SPK_LSB > 6) begin : g_chk_fld
        $error("dmscp_device: gain field outside register");
    end

    // Same field extraction for either command layout
    function automatic logic [7:0] dmscp_cmd_addr(input logic [7:0] b, input int alsb);
        return (b >> alsb) & AMASK;
    endfunction : dmscp_cmd_addr

    // Only the first gain register is mapped
    function automatic logic dmscp_gain1_hit(input logic [7:0] a);
        return (a == `DMSCP_GAIN1_ADDR);
    endfunction : dmscp_gain1_hit

    dmscp_pkg::dmscp_dlnk_s  l_r;
    dmscp_pkg::dmscp_dlnk_s  l_nxt;
    dmscp_pkg::dmscp_dhold_s h_r;
    dmscp_pkg::dmscp_dhold_s h_nxt;
    dmscp_pkg::dmscp_dneg_s  n_r;
    dmscp_pkg::dmscp_dneg_s  n_nxt;
    dmscp_pkg::dmscp_dref_s  r_r;
    dmscp_pkg::dmscp_dref_s  r_nxt;

    logic       pend_s;
    logic [1:0] irq_in_s;
    logic       mode_now;
    logic       bit_in;
    logic [7:0] sh_in;
    logic [7:0] cmd_addr;
    logic       cmd_rd;
    logic [2:0] k_idx;

    // Link side, rising edges; session state dies with select
    always_comb begin
        l_nxt    = l_r;
        h_nxt    = h_r;
        cmd_addr = '0;
        cmd_rd   = 1'b0;
        // A falling edge before the first rising one means the clock idled high
        mode_now = (l_r.cnt == 5'h00) ? n_r.fell : l_r.lsb;
        // Shared line in LSB mode, second line otherwise
        bit_in   = mode_now ? link.bidir_serial_line
                            : link.receive_serial_line;
        sh_in    = mode_now ? {bit_in, l_r.sh[7:1]}
                            : {l_r.sh[6:0], bit_in};
        if (l_r.cnt < `DMSCP_FRAME_BITS) begin
            l_nxt.cnt = l_r.cnt + 5'h01;
            l_nxt.lsb = mode_now;
            // Incoming bits during a read are shifted but never used
            l_nxt.sh  = sh_in;
            if (l_r.cnt == `DMSCP_BYTE_LAST) begin
                if (mode_now) begin
                    cmd_rd   = (sh_in[LSB_RW_POS] == `DMSCP_RW_READ);
                    cmd_addr = dmscp_cmd_addr(sh_in, LSB_ALSB);
                end else begin
                    cmd_rd   = (sh_in[MSB_RW_POS] == `DMSCP_RW_READ);
                    cmd_addr = dmscp_cmd_addr(sh_in, MSB_ALSB);
                end
                l_nxt.rd  = cmd_rd;
                l_nxt.hit = dmscp_gain1_hit(cmd_addr);
                // Unmapped addresses read as zero; gain only moves after a
                // session's last clock, so it is steady when taken here
                l_nxt.tx  = (cmd_rd && dmscp_gain1_hit(cmd_addr)) ? r_r.gain : 8'h00;
            end
            if (l_r.cnt == `DMSCP_FRAME_LAST && !l_r.rd) begin
                h_nxt.wdat = sh_in;
                h_nxt.hit  = l_r.hit;
                l_nxt.pend = 1'b1;
            end
        end
    end

    // Select high is the only reset the link side ever sees
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Write data must outlive the session, so it has no reset
    always_ff @(posedge link.sclk) begin
        h_r <= h_nxt;
    end

    // Link side, falling edges: output bit and its enable
    always_comb begin
        n_nxt      = n_r;
        n_nxt.fell = 1'b1;
        k_idx      = l_r.cnt[2:0];
        n_nxt.oe   = l_r.rd && l_r.cnt >= `DMSCP_DATA_FIRST
                            && l_r.cnt <= `DMSCP_FRAME_LAST;
        if (n_nxt.oe) begin
            n_nxt.dout = l_r.lsb ? l_r.tx[k_idx]
                                 : l_r.tx[3'h7 - k_idx];
        end
    end

    // Select high clears enable at once, no clock needed
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            n_r <= '0;
        end else begin
            n_r <= n_nxt;
        end
    end

    assign link.dev_o  = n_r.dout;
    assign link.dev_oe = n_r.oe;

    // Write request crosses as a level held until select rises
    dmscp_sync #(
        .W (1)
    ) i_dmscp_sync (
        .clk     (ref_clk),
        .reset_n (reset_n),
        .d       (l_r.pend),
        .q       (pend_s)
    );

    // Interrupt qualifiers come from outside this clock domain
    dmscp_sync #(
        .W (2)
    ) i_dmscp_sync_irq (
        .clk     (ref_clk),
        .reset_n (reset_n),
        .d       ({stream_bus_mode, contention}),
        .q       (irq_in_s)
    );

    always_comb begin
        r_nxt        = r_r;
        r_nxt.pend_d = pend_s;
        // One update per write: edge of the crossed request
        if (pend_s && !r_r.pend_d && h_r.hit) begin
            r_nxt.gain = h_r.wdat;
        end
        r_nxt.irq    = irq_in_s[1] && irq_in_s[0];
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            r_r.pend_d <= 1'b0;
            r_r.gain   <= `DMSCP_GAIN1_RST;
            r_r.irq    <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign mic_gain_boost    = r_r.gain[`DMSCP_MIC_BIT];
    assign speaker_gain_step = r_r.gain[`DMSCP_SPK_LSB +: 2];
    assign gain_control_one  = r_r.gain;
    // Open drain: only ever pulls low
    assign irq_n_o           = 1'b0;
    // Registered so the pin cannot glitch on input skew
    assign irq_n_oe          = r_r.irq;

endmodule : dmscp_device

// [logic/dmscp_cfg.svh]
// Behaviour
// - Clock high at select: LSB-first, shared line
// - Clock low at select: MSB-first, split lines
// - Controller uses clock polarity/phase zero in MSB mode; in LSB mode the clock idles high
// - Half-duplex; device ignores bits during reads
// - Controller discards bits received during writes
// - Each access: command byte, then data byte
// - Controller holds select for whole session
// - First eight clocks shift in command byte
// - Command byte gives direction and register address
// - Next eight clocks move the data byte
// - Select high releases shared data output
// - Data byte order follows detected mode
// - Command layout differs per mode
// - Sample on rising edge, present on falling
// - Open-drain contention interrupt in streaming mode
// - Register 00h bit selects microphone gain
// - Register 00h step sets speaker gain
`ifndef DMSCP_CFG_SVH
`define DMSCP_CFG_SVH

`define DMSCP_GAIN1_ADDR   8'h00
`define DMSCP_GAIN1_RST    8'h00
`define DMSCP_MIC_BIT      0
`define DMSCP_SPK_LSB      1
`define DMSCP_RW_READ      1'b1
`define DMSCP_MSB_RW_POS   7
`define DMSCP_MSB_ADDR_LSB 0
`define DMSCP_LSB_RW_POS   0
`define DMSCP_LSB_ADDR_LSB 1
`define DMSCP_ADDR_W       4
`define DMSCP_BYTE_LAST    5'h07
`define DMSCP_DATA_FIRST   5'h08
`define DMSCP_FRAME_LAST   5'h0f
`define DMSCP_FRAME_BITS   5'h10
`define DMSCP_HALF_DIV     5
`define DMSCP_HALF_MIN     4

`endif

// [logic/dmscp_pkg.sv]
`include "dmscp_cfg.svh"

package dmscp_pkg;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_SETUP,
        HST_LEAD,
        HST_LOW,
        HST_HIGH,
        HST_TAIL
    } dmscp_hst_e;

    typedef struct packed {
        logic [4:0] cnt;
        logic       lsb;
        logic       rd;
        logic       hit;
        logic [7:0] sh;
        logic [7:0] tx;
        logic       pend;
    } dmscp_dlnk_s;

    typedef struct packed {
        logic [7:0] wdat;
        logic       hit;
    } dmscp_dhold_s;

    typedef struct packed {
        logic fell;
        logic dout;
        logic oe;
    } dmscp_dneg_s;

    typedef struct packed {
        logic       pend_d;
        logic [7:0] gain;
        logic       irq;
    } dmscp_dref_s;

    typedef struct packed {
        dmscp_hst_e  st;
        logic [7:0]  div;
        logic        sclk;
        logic        csn;
        logic [4:0]  bitn;
        logic [15:0] frame;
        logic [7:0]  rx;
        logic        lsb;
        logic        rd;
        logic        dout;
        logic        oe;
        logic        done;
        logic [7:0]  rdata;
    } dmscp_host_s;

    function automatic logic [7:0] dmscp_bitrev(input logic [7:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction : dmscp_bitrev

    function automatic logic [7:0] dmscp_cmd_pack(input logic rd, input logic [7:0] addr,
                                                  input int rwp, input int alsb);
        logic [7:0] c;
        c      = 8'(addr << alsb);
        c[rwp] = rd;
        return c;
    endfunction : dmscp_cmd_pack

endpackage : dmscp_pkg

// [logic/dmscp_if.sv]
`timescale 1ns/1ps

interface dmscp_if;
    logic sclk;
    logic cs_n;
    logic receive_serial_line;
    logic dev_o;
    logic dev_oe;
    logic host_o;
    logic host_oe;
    logic bidir_serial_line;

    // Pull-up when nobody drives the shared line
    assign bidir_serial_line = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);

    modport device (
        input  sclk,
        input  cs_n,
        input  receive_serial_line,
        input  bidir_serial_line,
        output dev_o,
        output dev_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output receive_serial_line,
        output host_o,
        output host_oe,
        input  bidir_serial_line
    );
endinterface : dmscp_if

// [logic/dmscp_sync.sv]
`timescale 1ns/1ps

module dmscp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dmscp_sync_s;

    dmscp_sync_s s_r;
    dmscp_sync_s s_nxt;

    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule : dmscp_sync

// [logic/dmscp_host.sv]
`timescale 1ns/1ps
`include "dmscp_cfg.svh"

module dmscp_host #(
    parameter int ADDR_W     = `DMSCP_ADDR_W,
    parameter int HALF_DIV   = `DMSCP_HALF_DIV,
    parameter int MSB_RW_POS = `DMSCP_MSB_RW_POS,
    parameter int MSB_ALSB   = `DMSCP_MSB_ADDR_LSB,
    parameter int LSB_RW_POS = `DMSCP_LSB_RW_POS,
    parameter int LSB_ALSB   = `DMSCP_LSB_ADDR_LSB
) (
    dmscp_if.host               link,
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    input  wire logic           start,
    input  wire logic           lsb_first,
    input  wire logic           rd,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]     wdata,
    output logic                busy,
    output logic                done,
    output logic [7:0]          rdata
);

    // Two sync stages must settle inside one half period
    if (HALF_DIV < `DMSCP_HALF_MIN || HALF_DIV > 255) begin : g_chk_div
        $error("dmscp_host: half period divider out of range");
    end
    if (ADDR_W < 1 || ADDR_W > 7) begin : g_chk_aw
        $error("dmscp_host: address width out of range");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);

    dmscp_pkg::dmscp_host_s h_r;
    dmscp_pkg::dmscp_host_s h_nxt;
    logic       rx_s;
    logic       tick;
    logic [7:0] cmd;
    logic [4:0] nb;

    dmscp_sync #(
        .W (1)
    ) i_dmscp_sync (
        .clk     (ref_clk),
        .reset_n (reset_n),
        .d       (link.bidir_serial_line),
        .q       (rx_s)
    );

    always_comb begin
        h_nxt      = h_r;
        h_nxt.done = 1'b0;
        tick       = (h_r.div == HALF_LAST);
        nb         = h_r.bitn + 5'h01;
        cmd        = lsb_first ? dmscp_pkg::dmscp_cmd_pack(rd, 8'(addr), LSB_RW_POS, LSB_ALSB)
                               : dmscp_pkg::dmscp_cmd_pack(rd, 8'(addr), MSB_RW_POS, MSB_ALSB);
        h_nxt.div  = tick ? 8'h00 : h_r.div + 8'h01;
        case (h_r.st)
            dmscp_pkg::HST_IDLE: begin
                h_nxt.div = 8'h00;
                if (start) begin
                    h_nxt.lsb   = lsb_first;
                    h_nxt.rd    = rd;
                    // Idle clock level announces the mode
                    h_nxt.sclk  = lsb_first;
                    h_nxt.frame = lsb_first ? {dmscp_pkg::dmscp_bitrev(cmd), dmscp_pkg::dmscp_bitrev(wdata)}
                                            : {cmd, wdata};
                    h_nxt.bitn  = 5'h00;
                    h_nxt.st    = dmscp_pkg::HST_SETUP;
                end
            end
            dmscp_pkg::HST_SETUP: begin
                if (tick) begin
                    h_nxt.csn  = 1'b0;
                    h_nxt.dout = h_r.frame[15];
                    h_nxt.st   = dmscp_pkg::HST_LEAD;
                end
            end
            dmscp_pkg::HST_LEAD: begin
                if (tick) begin
                    h_nxt.sclk = 1'b0;
                    h_nxt.oe   = h_r.lsb;
                    h_nxt.st   = dmscp_pkg::HST_LOW;
                end
            end
            dmscp_pkg::HST_LOW: begin
                if (tick) begin
                    h_nxt.sclk = 1'b1;
                    h_nxt.st   = dmscp_pkg::HST_HIGH;
                end
            end
            dmscp_pkg::HST_HIGH: begin
                if (tick) begin
                    // Bits seen during a write are dropped
                    if (h_r.rd && h_r.bitn >= `DMSCP_DATA_FIRST) begin
                        h_nxt.rx = {h_r.rx[6:0], rx_s};
                    end
                    h_nxt.bitn  = nb;
                    h_nxt.frame = {h_r.frame[14:0], 1'b0};
                    if (h_r.bitn == `DMSCP_FRAME_LAST) begin
                        h_nxt.sclk = h_r.lsb;
                        h_nxt.oe   = 1'b0;
                        h_nxt.st   = dmscp_pkg::HST_TAIL;
                    end else begin
                        h_nxt.sclk = 1'b0;
                        h_nxt.dout = h_r.frame[14];
                        h_nxt.oe   = h_r.lsb && !(h_r.rd && nb >= `DMSCP_DATA_FIRST);
                        h_nxt.st   = dmscp_pkg::HST_LOW;
                    end
                end
            end
            dmscp_pkg::HST_TAIL: begin
                if (tick) begin
                    h_nxt.csn   = 1'b1;
                    h_nxt.done  = 1'b1;
                    h_nxt.rdata = h_r.lsb ? dmscp_pkg::dmscp_bitrev(h_r.rx) : h_r.rx;
                    h_nxt.st    = dmscp_pkg::HST_IDLE;
                end
            end
            default: begin
                h_nxt.st = dmscp_pkg::HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            h_r      <= '0;
            h_r.st   <= dmscp_pkg::HST_IDLE;
            h_r.csn  <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign link.sclk                = h_r.sclk;
    assign link.cs_n                = h_r.csn;
    assign link.host_o              = h_r.dout;
    assign link.host_oe             = h_r.oe;
    assign link.receive_serial_line = h_r.dout;
    assign busy                     = (h_r.st != dmscp_pkg::HST_IDLE);
    assign done                     = h_r.done;
    assign rdata                    = h_r.rdata;

endmodule : dmscp_host

// [testbench/dmscp_link_props.sv]
`timescale 1ns/1ps

module dmscp_link_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic receive_serial_line,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic bidir_serial_line
);
    // Counted in the fast domain; the link clock comes from host flops on ref_clk
    logic [4:0] rise_cnt_r;
    logic       sclk_r;
    logic       cs_n_r;
    logic       lsb_mode_r;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rise_cnt_r <= 5'h00;
            sclk_r     <= 1'b0;
            cs_n_r     <= 1'b1;
            lsb_mode_r <= 1'b0;
        end else begin
            sclk_r <= sclk;
            cs_n_r <= cs_n;
            if (cs_n) begin
                rise_cnt_r <= 5'h00;
            end else if (sclk && !sclk_r) begin
                rise_cnt_r <= rise_cnt_r + 5'h01;
            end
            if (cs_n_r && !cs_n) begin
                lsb_mode_r <= sclk;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_release_deselect: assert property (cs_n |-> !dev_oe)
        else $error("device drives shared line while deselected");
    a_no_early_drive: assert property (dev_oe |-> rise_cnt_r >= 5'h08)
        else $error("device drives during command byte");
    a_no_line_fight: assert property (!(dev_oe && host_oe))
        else $error("both ends drive shared line");
    a_msb_split_lines: assert property (!cs_n && !cs_n_r && !lsb_mode_r |-> !host_oe)
        else $error("host drives shared line in msb mode");
    a_lsb_shared_cmd: assert property (!cs_n && lsb_mode_r && rise_cnt_r inside {[1:7]} |-> host_oe)
        else $error("command not on shared line in lsb mode");
    a_clock_idle_level: assert property ($rose(cs_n) |-> sclk == lsb_mode_r)
        else $error("clock not at idle level at session end");
    a_two_bytes_only: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
        else $error("session not sixteen clocks");
    a_session_bounded: assert property ($fell(cs_n) |-> ##[100:300] $rose(cs_n))
        else $error("select not released in time");
    a_launch_on_fall: assert property ($rose(dev_oe) |-> $fell(sclk))
        else $error("read drive not started on falling edge");
    a_data_on_fall: assert property (dev_oe && $past(dev_oe) && $changed(dev_o) |-> $fell(sclk))
        else $error("read bit changed off falling edge");
    a_drive_window: assert property ($fell(dev_oe) |-> rise_cnt_r == 5'h10)
        else $error("read drive not eight clocks");
endmodule : dmscp_link_props

// [testbench/tb_dual_mode_serial_control_port.sv]
`timescale 1ns/1ps

module tb_dual_mode_serial_control_port;
    typedef struct packed {
        logic       rd;
        logic [7:0] val;
    } dmscp_note_s;

    logic        ref_clk;
    logic        reset_n;
    logic        start;
    logic        lsb_first;
    logic        rd;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        stream_bus_mode;
    logic        contention;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    logic        mic_gain_boost;
    logic [1:0]  speaker_gain_step;
    logic [7:0]  gain_control_one;
    logic        irq_n_o;
    logic        irq_n_oe;
    int          n_fail;
    int          checks_done;
    logic [7:0]  shadow;
    dmscp_note_s notes[$];

    dmscp_if link_if ();

    dmscp_device i_dmscp_device (
        .link(link_if), .ref_clk(ref_clk), .reset_n(reset_n), .stream_bus_mode(stream_bus_mode),
        .contention(contention), .mic_gain_boost(mic_gain_boost), .speaker_gain_step(speaker_gain_step),
        .gain_control_one(gain_control_one), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
    );

    dmscp_host i_dmscp_host (
        .link(link_if), .ref_clk(ref_clk), .reset_n(reset_n), .start(start), .lsb_first(lsb_first),
        .rd(rd), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata)
    );

    dmscp_link_props i_dmscp_link_props (
        .ref_clk(ref_clk), .reset_n(reset_n), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
        .receive_serial_line(link_if.receive_serial_line), .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe),
        .host_o(link_if.host_o), .host_oe(link_if.host_oe), .bidir_serial_line(link_if.bidir_serial_line)
    );

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic compare8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : compare8

    task automatic wait_busy(input logic level);
        int i;
        for (i = 0; i < 400 && busy !== level; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (busy !== level) begin
            n_fail++;
            $display("BAD t=%0t busy stuck", $time);
            report_and_stop();
        end
    endtask : wait_busy

    // Start is held into busy on purpose: a second take would leave a result with no note
    task automatic xfer(input logic lsb, input logic r, input logic [3:0] a, input logic [7:0] d);
        dmscp_note_s n;
        if (!r && a == 4'h0) begin
            shadow = d;
        end
        n.rd = r;
        n.val = (r && a != 4'h0) ? 8'h00 : shadow;
        notes.push_back(n);
        lsb_first = lsb;
        rd = r;
        addr = a;
        wdata = d;
        start = 1'b1;
        wait_busy(1'b1);
        repeat (2) @(posedge ref_clk);
        #1;
        start = 1'b0;
        wait_busy(1'b0);
    endtask : xfer

    always @(posedge ref_clk) begin
        dmscp_note_s n;
        if (reset_n === 1'b1 && done === 1'b1) begin
            if (notes.size() == 0) begin
                n_fail++;
                $display("BAD t=%0t result with no request", $time);
            end else begin
                n = notes.pop_front();
                if (n.rd) begin
                    compare8(rdata, n.val, "read data");
                end else begin
                    compare8(gain_control_one, n.val, "register");
                    compare8({7'h00, mic_gain_boost}, {7'h00, n.val[0]}, "mic gain");
                    compare8({6'h00, speaker_gain_step}, {6'h00, n.val[2:1]}, "speaker step");
                end
            end
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        #800000;
        n_fail++;
        $display("BAD t=%0t run did not finish", $time);
        report_and_stop();
    end

    initial begin
        logic [3:0] a;
        int m;
        int k;
        reset_n = 1'b0;
        start = 1'b0;
        lsb_first = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        stream_bus_mode = 1'b0;
        contention = 1'b0;
        n_fail = 0;
        checks_done = 0;
        shadow = 8'h00;
        void'($urandom(32'h416e3472));
        repeat (12) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        compare8(gain_control_one, 8'h00, "reset value");
        for (k = 0; k < 4; k++) begin
            {stream_bus_mode, contention} = 2'(k);
            repeat (4) @(posedge ref_clk);
            #1;
            compare8({6'h00, irq_n_oe, irq_n_o}, {6'h00, k == 3, 1'b0}, "interrupt");
        end
        for (m = 0; m < 2; m++) begin
            for (k = 0; k < 8; k++) begin
                xfer(m[0], 1'b0, 4'h0, {5'($urandom), 3'(k)}); // Every gain code
                xfer(~m[0], 1'b1, 4'h0, 8'($urandom)); // Read back in the other mode
            end
            a = 4'($urandom_range(15, 1));
            xfer(m[0], 1'b0, a, 8'($urandom)); // Other address dropped
            xfer(m[0], 1'b1, a, 8'($urandom)); // Controller bits during read ignored
            xfer(m[0], 1'b1, 4'h0, 8'hff); // Register untouched
        end
        repeat (5) @(posedge ref_clk);
        if (notes.size() != 0) begin
            n_fail++;
            $display("BAD t=%0t results missing", $time);
        end
        report_and_stop();
    end
endmodule : tb_dual_mode_serial_control_port
